// *** verilog/adf_consts.svh ***
// Constants for the converter DMA flag and overflow block.
// Assumes inclusion by the package and the block's single design file.
`ifndef ADF_CONSTS_SVH
`define ADF_CONSTS_SVH

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define ADF_CTL_OPS_COMPLETE    7'd6
`define ADF_CTL_CONV1_ERR       7'd4
`define ADF_CTL_CONV0_ERR       7'd3
`define ADF_CTL_WARN_EN         7'd2
`define ADF_CTL_CONV1_WARN      7'd1
`define ADF_CTL_CONV0_WARN      7'd0

// ----------------------------------------
// Configuration register bit positions
// ----------------------------------------
`define ADF_CFG_RPT_IRQ_EN      7'd3
`define ADF_CFG_RPT_FLAG        7'd2
`define ADF_CFG_EOO_IRQ_EN      7'd1
`define ADF_CFG_EOO_FLAG        7'd0

// Interrupt request bit in the second extended interrupt register
`define ADF_IRQ_BIT             7'd7

// ----------------------------------------
// Widths, depths and reset values
// ----------------------------------------
`define ADF_CONV_W              16
`define ADF_FIFO_DEPTH          8
`define ADF_REG_RESET           8'h00

`endif

// *** verilog/adf_pkg.sv ***
// Types shared by the converter DMA flag and overflow block.
// Assumes the constants header is on the include path.
`include "adf_consts.svh"

package adf_pkg;

  // One converter's completion strobe with its result
  typedef struct packed {
    logic                   done;
    logic [`ADF_CONV_W-1:0] data;
  } adf_conv_type;

  // One word headed for expansion RAM, tagged with its converter
  typedef struct packed {
    logic                   chan;
    logic [`ADF_CONV_W-1:0] data;
  } adf_ram_word_type;

  // Software clear strobes, one per sticky flag
  typedef struct packed {
    logic opsComplete;
    logic conv1Err;
    logic conv0Err;
    logic conv1Warn;
    logic conv0Warn;
    logic repeatLimit;
    logic endOfOp;
  } adf_flag_clear_type;

endpackage

// *** verilog/adf_dma_irq_overflow.sv ***
// Converter-to-RAM double buffering, overflow detection and DMA interrupt flags.
// Assumes results and control strobes are synchronous to clk_sys; RAM side may stall.
// Function
// - Any enabled source flag raises the single DMA interrupt request, bit 7.
// - Set ops-complete flag when all operations end and the interface is idle.
// - Converter 1 error flag, bit 4, when a converter 1 result is lost.
// - Converter 0 error flag, bit 3, when a converter 0 result is lost.
// - Converter 1 warning flag, bit 1, when its result finds buffer still full.
// - Converter 0 warning flag, bit 0, when its result finds buffer still full.
// - Control bit 2 gates both warning flags onto the interrupt.
// - Set repeat-limit flag, configuration bit 2, when the counter hits its limit.
// - Configuration bit 3 gates the repeat-limit flag onto the interrupt.
// - Set end-of-operation flag, configuration bit 0, on an end instruction.
// - Configuration bit 1 gates the end-of-operation flag onto the interrupt.
// - Each path is double-buffered: data register, then internal DMA buffer.
// - A result reaching an empty buffer is copied into it at once.
// - A full buffer goes to RAM at the first cycle access is free.
// - No copy into the buffer until its contents have reached RAM; the code refills it in the cycle they drain into the FIFO.
// - A result arriving while the buffer is unwritten sets that warning flag.
// - A second such result overwrites the data register and sets the error flag.
`timescale 1ns/10ps
`include "adf_consts.svh"

// ----------------------------------------
// Synchronous FIFO with registered storage
// ----------------------------------------
module adf_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  function automatic logic [PW-1:0] ptrNext(input logic [PW-1:0] ptr);
    ptrNext = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
  endfunction

  assign inReady  = (count_q != CW'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= ptrNext(wrPtr_q);
      if (pop) rdPtr_q <= ptrNext(rdPtr_q);
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule

// ----------------------------------------
// Top: flags, interrupt and buffered paths
// ----------------------------------------
module adf_dma_irq_overflow (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire adf_pkg::adf_conv_type     conv0In,
  input  wire adf_pkg::adf_conv_type     conv1In,
  input  wire logic                      opsDone,
  input  wire logic                      repeatLimitHit,
  input  wire logic                      endOfOpHit,
  input  wire logic                      overflow_warning_enable,
  input  wire logic                      repeat_limit_irq_enable,
  input  wire logic                      end_of_op_irq_enable,
  input  wire adf_pkg::adf_flag_clear_type flagClear,
  output adf_pkg::adf_ram_word_type      ramWord,
  output logic                           ramValid,
  input  wire logic                      ramReady,
  output logic [7:0]                     dma_control_reg,
  output logic [7:0]                     dma_config_reg,
  output logic                           ext_irq_enable_two_irq
);
  localparam int CHN = 2;

  // ----------------------------------------
  // Per-converter double buffer
  // ----------------------------------------
  adf_pkg::adf_conv_type   convIn [CHN];
  logic [`ADF_CONV_W-1:0]  dataReg_q [CHN];
  logic [`ADF_CONV_W-1:0]  bufData_q [CHN];
  logic [CHN-1:0]          dataPend_q;
  logic [CHN-1:0]          bufFull_q;
  logic [CHN-1:0]          drain;
  logic [CHN-1:0]          bufLoad;
  logic [CHN-1:0]          moveUp;
  logic [CHN-1:0]          warnSet;
  logic [CHN-1:0]          errSet;
  logic                    lastSel_q;
  logic                    fifoInReady;
  logic                    fifoOutValid;
  adf_pkg::adf_ram_word_type fifoOut;
  adf_pkg::adf_ram_word_type fifoIn;

  assign convIn[0] = conv0In;
  assign convIn[1] = conv1In;

  // Round-robin so one busy converter cannot starve the other
  assign drain[0] = bufFull_q[0] && fifoInReady && (!bufFull_q[1] || lastSel_q);
  assign drain[1] = bufFull_q[1] && fifoInReady && (!bufFull_q[0] || !lastSel_q);
  assign fifoIn.chan = drain[1];
  assign fifoIn.data = drain[1] ? bufData_q[1] : bufData_q[0];

  genvar gi;
  generate
    for (gi = 0; gi < CHN; gi++) begin : gPath
      wire done = convIn[gi].done;
      // Buffer counts as busy in the cycle it drains, so a same-cycle result is still a warning
      assign bufLoad[gi] = done && !bufFull_q[gi] && !dataPend_q[gi];
      assign moveUp[gi]  = dataPend_q[gi] && (!bufFull_q[gi] || drain[gi]);
      assign warnSet[gi] = done && (bufFull_q[gi] || dataPend_q[gi]);
      assign errSet[gi]  = done && dataPend_q[gi] && !moveUp[gi];

      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          dataReg_q[gi]  <= '0;
          bufData_q[gi]  <= '0;
          dataPend_q[gi] <= 1'b0;
          bufFull_q[gi]  <= 1'b0;
        end else begin
          if (done) dataReg_q[gi] <= convIn[gi].data;
          if (bufLoad[gi]) begin
            bufData_q[gi] <= convIn[gi].data;
          end else if (moveUp[gi]) begin
            bufData_q[gi] <= dataReg_q[gi];
          end
          bufFull_q[gi]  <= bufLoad[gi] || moveUp[gi] || (bufFull_q[gi] && !drain[gi]);
          dataPend_q[gi] <= (done && !bufLoad[gi]) || (dataPend_q[gi] && !moveUp[gi]);
        end
      end
    end
  endgenerate

  adf_fifo #(
    .WIDTH ($bits(adf_pkg::adf_ram_word_type)),
    .DEPTH (`ADF_FIFO_DEPTH)
  ) uFifo (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .inValid  (|drain),
    .inReady  (fifoInReady),
    .inData   (fifoIn),
    .outValid (fifoOutValid),
    .outReady (!ramValid || ramReady),
    .outData  (fifoOut)
  );

  // ----------------------------------------
  // RAM write stage
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ramValid  <= 1'b0;
      ramWord   <= '0;
      lastSel_q <= 1'b0;
    end else begin
      if (|drain) lastSel_q <= drain[1];
      if (!ramValid || ramReady) begin
        ramValid <= fifoOutValid;
        if (fifoOutValid) ramWord <= fifoOut;
      end
    end
  end

  // ----------------------------------------
  // Sticky flags, enables and interrupt
  // ----------------------------------------
  logic opsPend_q;
  logic ops_complete_flag;
  logic conv1_overflow_error;
  logic conv0_overflow_error;
  logic conv1_overflow_warning;
  logic conv0_overflow_warning;
  logic repeat_limit_flag;
  logic end_of_op_flag;
  logic warnEn_q;
  logic rptEn_q;
  logic eooEn_q;
  logic irqReq;

  // Completion waits until every accepted result has left the block
  wire pathIdle = !(|bufFull_q) && !(|dataPend_q) && !fifoOutValid && !ramValid;
  wire opsSet   = (opsDone || opsPend_q) && pathIdle;

  assign irqReq = ops_complete_flag || conv1_overflow_error || conv0_overflow_error
                  || (warnEn_q && (conv1_overflow_warning || conv0_overflow_warning))
                  || (rptEn_q && repeat_limit_flag)
                  || (eooEn_q && end_of_op_flag);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      opsPend_q              <= 1'b0;
      ops_complete_flag      <= 1'b0;
      conv1_overflow_error   <= 1'b0;
      conv0_overflow_error   <= 1'b0;
      conv1_overflow_warning <= 1'b0;
      conv0_overflow_warning <= 1'b0;
      repeat_limit_flag      <= 1'b0;
      end_of_op_flag         <= 1'b0;
      warnEn_q               <= 1'b0;
      rptEn_q                <= 1'b0;
      eooEn_q                <= 1'b0;
      ext_irq_enable_two_irq <= 1'b0;
    end else begin
      opsPend_q <= (opsDone || opsPend_q) && !pathIdle;
      // Set beats a same-cycle clear so no event is lost
      ops_complete_flag      <= opsSet || (ops_complete_flag && !flagClear.opsComplete);
      conv1_overflow_error   <= errSet[1] || (conv1_overflow_error && !flagClear.conv1Err);
      conv0_overflow_error   <= errSet[0] || (conv0_overflow_error && !flagClear.conv0Err);
      conv1_overflow_warning <= warnSet[1] || (conv1_overflow_warning && !flagClear.conv1Warn);
      conv0_overflow_warning <= warnSet[0] || (conv0_overflow_warning && !flagClear.conv0Warn);
      repeat_limit_flag      <= repeatLimitHit || (repeat_limit_flag && !flagClear.repeatLimit);
      end_of_op_flag         <= endOfOpHit || (end_of_op_flag && !flagClear.endOfOp);
      warnEn_q               <= overflow_warning_enable;
      rptEn_q                <= repeat_limit_irq_enable;
      eooEn_q                <= end_of_op_irq_enable;
      ext_irq_enable_two_irq <= irqReq;
    end
  end

  assign dma_control_reg = {1'b0, ops_complete_flag, 1'b0, conv1_overflow_error, conv0_overflow_error,
                            warnEn_q, conv1_overflow_warning, conv0_overflow_warning};
  assign dma_config_reg  = {4'h0, rptEn_q, repeat_limit_flag, eooEn_q, end_of_op_flag};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_irq_follows_src: assert property (irqReq |=> ext_irq_enable_two_irq)
    else $error("interrupt not raised by enabled flag");
  a_warn_gate_off: assert property (!warnEn_q && !ops_complete_flag && !conv1_overflow_error
      && !conv0_overflow_error && !(rptEn_q && repeat_limit_flag) && !(eooEn_q && end_of_op_flag)
      |=> !ext_irq_enable_two_irq)
    else $error("interrupt raised with no enabled flag");
  a_ops_after_idle: assert property (opsDone && pathIdle |=> dma_control_reg[6])
    else $error("ops complete flag missing");
  a_err1_lost: assert property (conv1In.done && dataPend_q[1] && bufFull_q[1] && !drain[1]
      |=> dma_control_reg[4])
    else $error("converter 1 error flag missing");
  a_err0_lost: assert property (conv0In.done && dataPend_q[0] && bufFull_q[0] && !drain[0]
      |=> dma_control_reg[3])
    else $error("converter 0 error flag missing");
  a_warn_both: assert property ((conv1In.done && bufFull_q[1] |=> dma_control_reg[1])
      and (conv0In.done && bufFull_q[0] |=> dma_control_reg[0]))
    else $error("warning flag missing");
  a_rpt_set: assert property (repeatLimitHit |=> dma_config_reg[2])
    else $error("repeat flag missing");
  a_eoo_set: assert property (endOfOpHit |=> dma_config_reg[0])
    else $error("end of operation flag missing");
  a_copy_empty: assert property (bufLoad[0] |=> bufFull_q[0] && bufData_q[0] == $past(conv0In.data))
    else $error("result not copied to empty buffer");
  a_hold_until_ram: assert property (bufFull_q[0] && !drain[0] |=> bufFull_q[0] && $stable(bufData_q[0]))
    else $error("buffer changed before reaching RAM");
  a_drain_first: assert property (bufFull_q[0] && !bufFull_q[1] && fifoInReady |-> drain[0])
    else $error("buffer not drained at first chance");
  a_flag_sticky: assert property (ops_complete_flag && !flagClear.opsComplete |=> ops_complete_flag)
    else $error("flag dropped without clear");
  a_clear_drops: assert property (flagClear.endOfOp && !endOfOpHit |=> !end_of_op_flag)
    else $error("flag kept after clear");
  a_ops_wait: assert property (!pathIdle && !ops_complete_flag |=> !ops_complete_flag)
    else $error("ops complete flag set while path busy");
  a_ram_stands: assert property (ramValid && !ramReady |=> ramValid && $stable(ramWord))
    else $error("RAM word changed before acceptance");
  a_copy_empty1: assert property (bufLoad[1] |=> bufFull_q[1] && bufData_q[1] == $past(conv1In.data))
    else $error("converter 1 result not copied to empty buffer");
  a_hold_until_ram1: assert property (bufFull_q[1] && !drain[1] |=> bufFull_q[1] && $stable(bufData_q[1]))
    else $error("converter 1 buffer changed before reaching RAM");
  a_drain_first1: assert property (bufFull_q[1] && !bufFull_q[0] && fifoInReady |-> drain[1])
    else $error("converter 1 buffer not drained at first chance");
  a_pend_newest: assert property (conv0In.done |=> dataReg_q[0] == $past(conv0In.data))
    else $error("data register not holding newest result");
endmodule

// *** verif/adf_ram_model.sv ***
// Expansion RAM stand-in on the block's RAM word port.
// Assumes the bench supplies the stall level; one clock, synchronous reset.
`timescale 1ns/10ps

// ----------------------------------------
// RAM acceptor with stall control
// ----------------------------------------
module adf_ram_model (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic                      hold,
  input  wire logic                      ramValid,
  input  wire adf_pkg::adf_ram_word_type ramWord,
  output logic                           ramReady,
  output logic [15:0]                    lastData_q
);
  // Stalls only when told; a real RAM port may be busy for many cycles
  assign ramReady = ~hold;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lastData_q <= 16'h0000;
    end else if (ramValid && ramReady) begin
      lastData_q <= ramWord.data;
    end
  end
endmodule

// *** verif/adf_dma_irq_overflow_bench.sv ***
// Self-checking bench for the converter DMA flag and overflow block.
// Assumes the design files and the RAM model are compiled first.
`timescale 1ns/10ps

module adf_dma_irq_overflow_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic                         clk_sys = 1'b0;
  logic                         rst_b = 1'b0;
  adf_pkg::adf_conv_type        conv0In = '0;
  adf_pkg::adf_conv_type        conv1In = '0;
  logic                         opsDone = 1'b0;
  logic                         repeatLimitHit = 1'b0;
  logic                         endOfOpHit = 1'b0;
  logic                         warnEn = 1'b0;
  logic                         rptEn = 1'b0;
  logic                         eooEn = 1'b0;
  logic                         hold = 1'b0;
  adf_pkg::adf_flag_clear_type  flagClear = '0;
  adf_pkg::adf_ram_word_type    ramWord;
  logic                         ramValid;
  logic                         ramReady;
  logic                         irq;
  logic [7:0]                   ctlReg;
  logic [7:0]                   cfgReg;
  logic [15:0]                  ramLast;
  logic [15:0]                  lfsr = 16'h001A;
  logic [15:0]                  expQ [2][$];
  int                           nFail = 0;
  int                           totalChecks = 0;
  int                           nSkip = 0;
  int                           cycles = 0;
  int                           ch;

  always #5 clk_sys = ~clk_sys;

  adf_dma_irq_overflow i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .conv0In(conv0In), .conv1In(conv1In),
    .opsDone(opsDone), .repeatLimitHit(repeatLimitHit), .endOfOpHit(endOfOpHit),
    .overflow_warning_enable(warnEn), .repeat_limit_irq_enable(rptEn), .end_of_op_irq_enable(eooEn),
    .flagClear(flagClear), .ramWord(ramWord), .ramValid(ramValid), .ramReady(ramReady),
    .dma_control_reg(ctlReg), .dma_config_reg(cfgReg), .ext_irq_enable_two_irq(irq));

  adf_ram_model i_ram (.clk_sys(clk_sys), .rst_b(rst_b), .hold(hold), .ramValid(ramValid),
    .ramWord(ramWord), .ramReady(ramReady), .lastData_q(ramLast));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic sendConv(input int c);
    @(posedge clk_sys);
    lfsr = lfsr_next(lfsr);
    if (c == 0) conv0In <= '{1'b1, lfsr};
    else conv1In <= '{1'b1, lfsr};
    expQ[c].push_back(lfsr);
  endtask

  task automatic quiet();
    @(posedge clk_sys);
    conv0In.done <= 1'b0;
    conv1In.done <= 1'b0;
    opsDone <= 1'b0;
    repeatLimitHit <= 1'b0;
    endOfOpHit <= 1'b0;
    flagClear <= '0;
  endtask

  task automatic clearAll();
    @(posedge clk_sys);
    flagClear <= '1;
    quiet();
  endtask

  task giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // RAM scoreboard and hang guard
  // ----------------------------------------
  // Lost results are allowed only as gaps; order must hold per converter
  always @(posedge clk_sys) begin
    cycles++;
    if (rst_b === 1'b1 && ramValid === 1'b1 && ramReady === 1'b1) begin
      ch = int'(ramWord.chan === 1'b1);
      while (expQ[ch].size() > 0 && expQ[ch][0] !== ramWord.data) begin
        void'(expQ[ch].pop_front());
        nSkip++;
      end
      check(expQ[ch].size() > 0, 1);
      if (expQ[ch].size() > 0) void'(expQ[ch].pop_front());
    end
    if (cycles == 3000) begin
      nFail++;
      giveVerdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(1);
    check({ctlReg, cfgReg, ramValid, irq}, 0);
    for (int k = 0; k < 3; k++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge clk_sys);
        rptEn <= e[0];
        eooEn <= e[0];
        cyc(3);
        @(posedge clk_sys);
        if (k == 0) opsDone <= 1'b1;
        else if (k == 1) repeatLimitHit <= 1'b1;
        else endOfOpHit <= 1'b1;
        quiet();
        cyc(1);
        check({ctlReg[6], cfgReg[2], cfgReg[0]}, 3'b100 >> k);
        check(irq, k == 0 || e == 1);
        check({cfgReg[3], cfgReg[1]}, {e[0], e[0]});
        clearAll();
        cyc(2);
        check({ctlReg[6], cfgReg[2], cfgReg[0], irq}, 0);
      end
    end
    // Set and clear in the same cycle: set must win
    @(posedge clk_sys);
    repeatLimitHit <= 1'b1;
    flagClear.repeatLimit <= 1'b1;
    quiet();
    cyc(1);
    check(cfgReg[2], 1);
    clearAll();
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      warnEn <= 1'b0;
      sendConv(c);
      sendConv(c);
      quiet();
      cyc(4);
      check(ctlReg[1:0], c == 1 ? 2'b10 : 2'b01);
      check({ctlReg[4:3], irq}, 0);
      @(posedge clk_sys);
      warnEn <= 1'b1;
      cyc(3);
      check({ctlReg[2], irq}, 2'b11);
      clearAll();
      cyc(2);
      check(irq, 0);
    end
    // Ops complete waits for the stalled word to reach RAM
    @(posedge clk_sys);
    hold <= 1'b1;
    sendConv(0);
    quiet();
    @(posedge clk_sys);
    opsDone <= 1'b1;
    quiet();
    cyc(6);
    check(ctlReg[6], 0);
    @(posedge clk_sys);
    hold <= 1'b0;
    cyc(10);
    check(ctlReg[6], 1);
    check(ramLast, lfsr);
    clearAll();
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      warnEn <= 1'b0;
      hold <= 1'b1;
      nSkip = 0;
      repeat (16) begin
        sendConv(c);
        quiet();
      end
      cyc(2);
      check(ctlReg[4:3], c == 1 ? 2'b10 : 2'b01);
      check(ctlReg[1:0], c == 1 ? 2'b10 : 2'b01);
      check(irq, 1);
      @(posedge clk_sys);
      hold <= 1'b0;
      cyc(30);
      check(nSkip > 0, 1);
      check(expQ[c].size(), 0);
      clearAll();
    end
    nSkip = 0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      lfsr = lfsr_next(lfsr);
      hold <= (lfsr[1:0] == 2'b00);
      conv0In <= '{(i % 4 == 0) && lfsr[2], lfsr};
      conv1In <= '{(i % 4 == 2) && lfsr[3], ~lfsr};
      if ((i % 4 == 0) && lfsr[2]) expQ[0].push_back(lfsr);
      if ((i % 4 == 2) && lfsr[3]) expQ[1].push_back(~lfsr);
    end
    quiet();
    @(posedge clk_sys);
    hold <= 1'b0;
    cyc(20);
    check(nSkip, 0);
    check(expQ[0].size() + expQ[1].size(), 0);
    check(ctlReg[4:3], 0);
    giveVerdict();
  end
endmodule
